// *** logic/dvm_volume_mix.sv ***
// playback path control: mix, mute, gain registers, bit clock and filter group
`default_nettype none

// ****************************************************************
// Overview of operation
// - mix code selects stereo, copies, or average
// - master bit clock from mclk divider
// - ratio field auto or seven fixed ratios
// - zero cross bit gates gain changes
// - per channel mute bits silence channels
// - increase ramp bit, reset clear
// - decrease ramp bit, reset set
// - update bit applies both channels together
// - clear update bit only stores setting
// - 9-bit code, 0.25dB steps, saturates
// - wide ratios use 14.5 sample filter
// - 128/192 ratios use 6.5 sample filter
// ****************************************************************

module dvm_volume_mix
  import dvm_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input wire logic clk,  // master clock, 200 MHz
  input wire logic nrst,
  input wire logic reg_wr,  // register write strobe
  input wire logic reg_rd,  // register read strobe
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,  // read data, valid the cycle after reg_rd
  input wire logic master_mode,  // 1 = device makes the bit clock
  input wire logic [2:0] detected_ratio,  // ratio code found by auto detection
  input wire logic sample_valid,  // one stereo frame from the audio interface
  input wire logic [SAMPLE_W-1:0] left_in,
  input wire logic [SAMPLE_W-1:0] right_in,
  output logic out_valid,
  output logic [SAMPLE_W-1:0] left_out,
  output logic [SAMPLE_W-1:0] right_out,
  output logic [8:0] left_gain,  // gain code in use, left
  output logic [8:0] right_gain,  // gain code in use, right
  output logic bclk_out,
  output logic filter_narrow,  // 1 = 128/192 fs filter set
  output logic [7:0] filter_delay_x10  // group delay in tenths of a sample
);

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] mix_clk_reg;  // mix, divider and ratio fields
  logic [4:0] mute_ramp_reg;  // zero cross, mutes, ramp bits
  logic [8:0] left_code_reg;  // stored left setting
  logic [8:0] right_code_reg;  // stored right setting
  logic [8:0] left_applied_reg;  // left target in use
  logic [8:0] right_applied_reg;  // right target in use
  logic [15:0] rdata_reg;

  // write decode
  wire wr_mix = reg_wr && (reg_addr == DVM_OFS_MIX_CLK);
  wire wr_mute = reg_wr && (reg_addr == DVM_OFS_MUTE_RAMP);
  wire wr_left = reg_wr && (reg_addr == DVM_OFS_LEFT_GAIN);
  wire wr_right = reg_wr && (reg_addr == DVM_OFS_RIGHT_GAIN);
  wire apply_bit = reg_wdata[DVM_APPLY_BIT];
  wire apply_now = (wr_left || wr_right) && apply_bit;
  wire [8:0] wcode = reg_wdata[8:0];

  // field views
  wire [1:0] output_mix_select = mix_clk_reg[DVM_MIX_LSB+:2];
  wire [2:0] bit_clock_divider = mix_clk_reg[DVM_BCLK_LSB+:3];
  wire [2:0] clock_ratio_select = mix_clk_reg[DVM_RATIO_LSB+:3];
  wire zero_cross_enable = mute_ramp_reg[DVM_ZC_BIT];
  wire right_channel_mute = mute_ramp_reg[DVM_RMUTE_BIT];
  wire left_channel_mute = mute_ramp_reg[DVM_LMUTE_BIT];
  wire gain_increase_ramp = mute_ramp_reg[DVM_UP_RAMP_BIT];
  wire gain_decrease_ramp = mute_ramp_reg[DVM_DOWN_RAMP_BIT];

  // codes to apply: the one being written replaces its stored value
  wire [8:0] left_to_apply = wr_left ? wcode : left_code_reg;
  wire [8:0] right_to_apply = wr_right ? wcode : right_code_reg;
  wire [8:0] left_sat = (left_to_apply > DVM_GAIN_SAT) ? DVM_GAIN_SAT : left_to_apply;
  wire [8:0] right_sat = (right_to_apply > DVM_GAIN_SAT) ? DVM_GAIN_SAT : right_to_apply;

  // configuration registers; reset values put ramp down on, ramp up off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mix_clk_reg <= DVM_MIX_CLK_RESET;
      mute_ramp_reg <= DVM_MUTE_RAMP_RESET;
    end else begin
      if (wr_mix) begin
        mix_clk_reg <= reg_wdata[7:0];
      end
      if (wr_mute) begin
        mute_ramp_reg <= reg_wdata[4:0];
      end
    end
  end

  // stored settings and applied targets
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_code_reg <= DVM_GAIN_RESET;
      right_code_reg <= DVM_GAIN_RESET;
      left_applied_reg <= DVM_GAIN_RESET;
      right_applied_reg <= DVM_GAIN_RESET;
    end else begin
      if (wr_left) begin
        left_code_reg <= wcode;
      end
      if (wr_right) begin
        right_code_reg <= wcode;
      end
      if (apply_now) begin
        left_applied_reg <= left_sat;
        right_applied_reg <= right_sat;
      end
    end
  end

  // ****************************************************************
  // register read back; the update bit is a strobe and reads zero
  // ****************************************************************
  wire [15:0] rd_mux = (reg_addr == DVM_OFS_MIX_CLK) ? {8'h00, mix_clk_reg} :
                       (reg_addr == DVM_OFS_MUTE_RAMP) ? {11'h000, mute_ramp_reg} :
                       (reg_addr == DVM_OFS_LEFT_GAIN) ? {7'h00, left_code_reg} :
                       (reg_addr == DVM_OFS_RIGHT_GAIN) ? {7'h00, right_code_reg} : 16'h0000;

  // read data holds until the next read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // ****************************************************************
  // mix and mute
  // ****************************************************************
  logic [SAMPLE_W-1:0] left_out_reg;
  logic [SAMPLE_W-1:0] right_out_reg;
  logic out_valid_reg;
  // one extra bit keeps the sum from wrapping before the halving
  wire [SAMPLE_W:0] mix_sum = {left_in[SAMPLE_W-1], left_in} + {right_in[SAMPLE_W-1], right_in};
  wire [SAMPLE_W-1:0] mix_avg = mix_sum[SAMPLE_W:1];
  wire [SAMPLE_W-1:0] left_mixed = (output_mix_select == DVM_MIX_RIGHT_TO_BOTH) ? right_in :
                                   (output_mix_select == DVM_MIX_AVERAGE) ? mix_avg : left_in;
  wire [SAMPLE_W-1:0] right_mixed = (output_mix_select == DVM_MIX_LEFT_TO_BOTH) ? left_in :
                                    (output_mix_select == DVM_MIX_AVERAGE) ? mix_avg : right_in;

  // sample registers; a muted channel carries silence, not a small value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_out_reg <= '0;
      right_out_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= sample_valid;
      if (sample_valid) begin
        left_out_reg <= left_channel_mute ? '0 : left_mixed;
        right_out_reg <= right_channel_mute ? '0 : right_mixed;
      end
    end
  end

  // ****************************************************************
  // gain followers, one per channel
  // ****************************************************************
  wire [8:0] applied_arr [2];
  wire [8:0] gain_arr [2];
  wire neg_arr [2];
  assign applied_arr[0] = left_applied_reg;
  assign applied_arr[1] = right_applied_reg;
  assign neg_arr[0] = left_mixed[SAMPLE_W-1];
  assign neg_arr[1] = right_mixed[SAMPLE_W-1];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    dvm_gain_channel #(
      .CODE_W(9)
    ) u_gain (
      .clk(clk),
      .nrst(nrst),
      .sample_tick(sample_valid),
      .sample_neg(neg_arr[ch]),
      .target(applied_arr[ch]),
      .ramp_up(gain_increase_ramp),
      .ramp_down(gain_decrease_ramp),
      .zc_en(zero_cross_enable),
      .gain(gain_arr[ch])
    );
  end

  // ****************************************************************
  // clock ratio and bit clock
  // ****************************************************************
  // auto detect or fixed ratio
  wire [2:0] ratio_code = (clock_ratio_select == DVM_RATIO_AUTO) ? detected_ratio : clock_ratio_select;
  wire [10:0] ratio_mult = dvm_ratio_mult(ratio_code);
  logic [10:0] bclk_div;
  always_comb begin
    case (bit_clock_divider)
      DVM_BCLK_MCLK_DIV4: bclk_div = DVM_DIV4;
      DVM_BCLK_MCLK_DIV8: bclk_div = DVM_DIV8;
      DVM_BCLK_32FS: bclk_div = {5'h00, ratio_mult[10:5]};
      DVM_BCLK_64FS: bclk_div = {6'h00, ratio_mult[10:6]};
      DVM_BCLK_128FS: bclk_div = {7'h00, ratio_mult[10:7]};
      default: bclk_div = DVM_DIV4;
    endcase
  end
  // fractional halves (192 fs at 64 fs bit rate) round down; no jitter logic here
  wire [9:0] half_raw = bclk_div[10:1];
  wire [9:0] half_div = (half_raw == 10'h000) ? 10'h001 : half_raw;

  logic [9:0] bclk_cnt_reg;
  logic bclk_reg;
  wire bclk_wrap = (bclk_cnt_reg + 10'h001) >= half_div;

  // bit clock toggles every half period; parked low in slave mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bclk_cnt_reg <= 10'h000;
      bclk_reg <= 1'b0;
    end else if (!master_mode) begin
      bclk_cnt_reg <= 10'h000;
      bclk_reg <= 1'b0;
    end else if (bclk_wrap) begin
      bclk_cnt_reg <= 10'h000;
      bclk_reg <= !bclk_reg;
    end else begin
      bclk_cnt_reg <= bclk_cnt_reg + 10'h001;
    end
  end

  // ****************************************************************
  // filter group selection
  // ****************************************************************
  // 128 and 192 fs use the short filter
  wire narrow_now = (ratio_code == 3'h1) || (ratio_code == 3'h2);
  logic narrow_reg;
  logic [7:0] delay_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      narrow_reg <= 1'b0;
      delay_reg <= DVM_DELAY_WIDE_X10;
    end else begin
      narrow_reg <= narrow_now;
      // wide ratios take the long filter
      delay_reg <= narrow_now ? DVM_DELAY_NARROW_X10 : DVM_DELAY_WIDE_X10;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = rdata_reg;
  assign out_valid = out_valid_reg;
  assign left_out = left_out_reg;
  assign right_out = right_out_reg;
  assign left_gain = gain_arr[0];
  assign right_gain = gain_arr[1];
  assign bclk_out = bclk_reg;
  assign filter_narrow = narrow_reg;
  assign filter_delay_x10 = delay_reg;

endmodule : dvm_volume_mix

`default_nettype wire

// *** logic/dvm_pkg.sv ***
// package of constants shared by the playback volume and mix control block
`default_nettype none

package dvm_pkg;

  // ****************************************************************
  // register offsets (word index on the control port)
  // ****************************************************************
  localparam logic [6:0] DVM_OFS_MIX_CLK = 7'h04;  // mix_and_clock_divider_control
  localparam logic [6:0] DVM_OFS_MUTE_RAMP = 7'h05;  // mute_ramp_zero_cross_control
  localparam logic [6:0] DVM_OFS_LEFT_GAIN = 7'h06;  // left_channel_gain
  localparam logic [6:0] DVM_OFS_RIGHT_GAIN = 7'h07;  // right_channel_gain

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DVM_MIX_LSB = 6;  // output_mix_select [7:6]
  localparam int DVM_BCLK_LSB = 3;  // bit_clock_divider [5:3]
  localparam int DVM_RATIO_LSB = 0;  // clock_ratio_select [2:0]
  localparam int DVM_ZC_BIT = 4;  // zero_cross_enable
  localparam int DVM_RMUTE_BIT = 3;  // right_channel_mute
  localparam int DVM_LMUTE_BIT = 2;  // left_channel_mute
  localparam int DVM_UP_RAMP_BIT = 1;  // gain_increase_ramp
  localparam int DVM_DOWN_RAMP_BIT = 0;  // gain_decrease_ramp
  localparam int DVM_APPLY_BIT = 9;  // left/right_gain_apply_strobe

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DVM_MIX_CLK_RESET = 8'h00;
  localparam logic [4:0] DVM_MUTE_RAMP_RESET = 5'h01;
  localparam logic [8:0] DVM_GAIN_RESET = 9'h190;  // 0 dB
  localparam logic [8:0] DVM_GAIN_SAT = 9'h1BF;  // +11.75 dB, codes above saturate here

  // ****************************************************************
  // mix modes and bit clock divider codes
  // ****************************************************************
  localparam logic [1:0] DVM_MIX_STEREO = 2'h0;
  localparam logic [1:0] DVM_MIX_LEFT_TO_BOTH = 2'h1;
  localparam logic [1:0] DVM_MIX_RIGHT_TO_BOTH = 2'h2;
  localparam logic [1:0] DVM_MIX_AVERAGE = 2'h3;
  localparam logic [2:0] DVM_BCLK_MCLK_DIV4 = 3'h0;
  localparam logic [2:0] DVM_BCLK_MCLK_DIV8 = 3'h1;
  localparam logic [2:0] DVM_BCLK_32FS = 3'h2;
  localparam logic [2:0] DVM_BCLK_64FS = 3'h3;
  localparam logic [2:0] DVM_BCLK_128FS = 3'h4;
  localparam logic [2:0] DVM_RATIO_AUTO = 3'h0;
  localparam logic [10:0] DVM_DIV4 = 11'h004;
  localparam logic [10:0] DVM_DIV8 = 11'h008;

  // ****************************************************************
  // interpolation filter figures, in tenths of a sample or per mille of fs
  // ****************************************************************
  localparam logic [7:0] DVM_DELAY_WIDE_X10 = 8'h91;  // 14.5 sample periods
  localparam logic [7:0] DVM_DELAY_NARROW_X10 = 8'h41;  // 6.5 sample periods
  localparam int DVM_PASS_WIDE_PM = 454;
  localparam int DVM_STOP_WIDE_PM = 546;
  localparam int DVM_PASS_NARROW_PM = 247;
  localparam int DVM_STOP_NARROW_PM = 753;
  localparam int DVM_STOP_ATTEN_DB = 50;

  // master clock per frame clock for each fixed ratio code
  function automatic logic [10:0] dvm_ratio_mult(input logic [2:0] code);
    case (code)
      3'h1: dvm_ratio_mult = 11'h080;
      3'h2: dvm_ratio_mult = 11'h0C0;
      3'h3: dvm_ratio_mult = 11'h100;
      3'h4: dvm_ratio_mult = 11'h180;
      3'h5: dvm_ratio_mult = 11'h200;
      3'h6: dvm_ratio_mult = 11'h300;
      3'h7: dvm_ratio_mult = 11'h480;
      // auto code with nothing detected yet is treated as 256 fs
      default: dvm_ratio_mult = 11'h100;
    endcase
  endfunction : dvm_ratio_mult

endpackage : dvm_pkg

`default_nettype wire

// *** logic/dvm_gain_channel.sv ***
// one channel's gain follower: steps or ramps toward the applied code
`default_nettype none

module dvm_gain_channel
  import dvm_pkg::*;
#(
  parameter int CODE_W = 9
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample_tick,  // one new sample on this channel
  input wire logic sample_neg,  // sign of that sample
  input wire logic [CODE_W-1:0] target,  // applied, already saturated code
  input wire logic ramp_up,
  input wire logic ramp_down,
  input wire logic zc_en,
  output logic [CODE_W-1:0] gain
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [CODE_W-1:0] gain_reg;  // gain in use
  logic [CODE_W-1:0] gain_next;
  logic sign_reg;  // sign of the previous sample
  wire crossed = sample_neg != sign_reg;  // sign change seen on this sample
  wire may_move = !zc_en || crossed;
  wire rising = target > gain_reg;

  // next gain: one 0.25 dB step per sample while ramping
  always_comb begin
    gain_next = gain_reg;
    if (sample_tick && may_move && (target != gain_reg)) begin
      if (rising) begin
        gain_next = ramp_up ? gain_reg + 1'b1 : target;
      end else begin
        gain_next = ramp_down ? gain_reg - 1'b1 : target;
      end
    end
  end

  // gain and sign history; ramp speed is tied to the sample rate on purpose
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_reg <= CODE_W'(DVM_GAIN_RESET);
      sign_reg <= 1'b0;
    end else begin
      gain_reg <= gain_next;
      if (sample_tick) begin
        sign_reg <= sample_neg;
      end
    end
  end

  assign gain = gain_reg;

endmodule : dvm_gain_channel

`default_nettype wire

// *** tb/dvm_volume_mix_assertions.sv ***
// checker for the playback volume and mix block, bound to its top module
`default_nettype none

module dvm_volume_mix_assertions
  import dvm_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic master_mode,
  input wire logic [2:0] detected_ratio,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] left_in,
  input wire logic [SAMPLE_W-1:0] right_in,
  input wire logic out_valid,
  input wire logic [SAMPLE_W-1:0] left_out,
  input wire logic [SAMPLE_W-1:0] right_out,
  input wire logic [8:0] left_gain,
  input wire logic [8:0] right_gain,
  input wire logic bclk_out,
  input wire logic filter_narrow,
  input wire logic [7:0] filter_delay_x10
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ********
  // shadow of the control registers and expected samples
  // ********
  logic [7:0] mc_reg;  // mix and clock fields
  logic [4:0] mr_reg;  // mute, ramp and zero cross fields
  logic [SAMPLE_W-1:0] exp_l_reg;  // expected left after mix and mute
  logic [SAMPLE_W-1:0] exp_r_reg;  // expected right after mix and mute
  logic sgn_reg;  // left sign of the previous frame
  logic [SAMPLE_W:0] sum;  // one bit wider so the average cannot overflow
  logic [SAMPLE_W-1:0] mix_l;
  logic [SAMPLE_W-1:0] mix_r;
  logic [2:0] eff;  // ratio in force, auto falls back to the detected code
  logic nar;
  assign sum = {left_in[SAMPLE_W-1], left_in} + {right_in[SAMPLE_W-1], right_in};
  assign mix_l = mc_reg[7:6] == 2'h2 ? right_in : (mc_reg[7:6] == 2'h3 ? sum[SAMPLE_W:1] : left_in);
  assign mix_r = mc_reg[7:6] == 2'h1 ? left_in : (mc_reg[7:6] == 2'h3 ? sum[SAMPLE_W:1] : right_in);
  assign eff = mc_reg[2:0] == 3'h0 ? detected_ratio : mc_reg[2:0];
  assign nar = eff == 3'h1 || eff == 3'h2;

  // registers follow writes the same way the block does
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mc_reg <= 8'h00;
      mr_reg <= 5'h01;
    end else if (reg_wr && reg_addr == 7'h04) begin
      mc_reg <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == 7'h05) begin
      mr_reg <= reg_wdata[4:0];
    end
  end

  // expected outputs are taken at the frame edge, with the old settings
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exp_l_reg <= '0;
      exp_r_reg <= '0;
      sgn_reg <= 1'b0;
    end else if (sample_valid) begin
      exp_l_reg <= mr_reg[2] ? '0 : mix_l;
      exp_r_reg <= mr_reg[3] ? '0 : mix_r;
      sgn_reg <= mix_l[SAMPLE_W-1];
    end
  end

  // ********
  // assertions
  // ********
  AST_MIX_MUTE: assert property (out_valid |-> left_out == exp_l_reg && right_out == exp_r_reg)
    else $error("mixed or muted sample differs");
  AST_FRAME_VALID: assert property (sample_valid |=> out_valid ##1 (out_valid == $past(sample_valid)))
    else $error("output frame strobe wrong");
  AST_GAIN_ON_FRAME: assert property ($changed(left_gain) || $changed(right_gain) |-> $past(sample_valid))
    else $error("gain moved without a frame");
  AST_UP_RAMP: assert property ($past(mr_reg[1]) && left_gain > $past(left_gain)
    |-> left_gain == $past(left_gain) + 9'h001)
    else $error("ramped increase not one step");
  AST_DOWN_RAMP: assert property ($past(mr_reg[0]) && left_gain < $past(left_gain)
    |-> left_gain == $past(left_gain) - 9'h001)
    else $error("ramped decrease not one step");
  AST_ZERO_CROSS: assert property ($past(mr_reg[4]) && $changed(left_gain)
    |-> $past(mix_l[SAMPLE_W-1]) != $past(sgn_reg))
    else $error("gain changed without sign change");
  AST_BCLK_DIV4: assert property ((master_mode && mc_reg[5:3] == 3'h0 && $stable(mc_reg)) [*8]
    ##0 $rose(bclk_out) |-> ##1 bclk_out ##1 !bclk_out)
    else $error("bit clock not master clock over four");
  AST_BCLK_IDLE: assert property (!master_mode [*2] |-> !bclk_out)
    else $error("bit clock runs in slave mode");
  AST_FILTER_GROUP: assert property ($past(nrst) |-> filter_narrow == $past(nar)
    && filter_delay_x10 == ($past(nar) ? 8'h41 : 8'h91))
    else $error("filter group does not match ratio");

  // main scenarios reached
  cover property (sample_valid && mc_reg[7:6] == 2'h3);
  cover property ($past(mr_reg[4]) && $changed(left_gain));
  cover property (master_mode && $rose(bclk_out));

endmodule : dvm_volume_mix_assertions

bind dvm_volume_mix dvm_volume_mix_assertions #(.SAMPLE_W(SAMPLE_W)) u_dvm_volume_mix_assertions (
  .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .master_mode(master_mode), .detected_ratio(detected_ratio),
  .sample_valid(sample_valid), .left_in(left_in), .right_in(right_in), .out_valid(out_valid),
  .left_out(left_out), .right_out(right_out), .left_gain(left_gain), .right_gain(right_gain),
  .bclk_out(bclk_out), .filter_narrow(filter_narrow), .filter_delay_x10(filter_delay_x10)
);

`default_nettype wire

// *** tb/dvm_audio_source.sv ***
// model of the digital audio source feeding stereo frames
`default_nettype none

module dvm_audio_source #(
  parameter int SAMPLE_W = 24
) (
  input wire logic clk,
  output logic sample_valid,
  output logic [SAMPLE_W-1:0] left_in,
  output logic [SAMPLE_W-1:0] right_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sample_valid = 1'b0;
    left_in = '0;
    right_in = '0;
  end

  // one frame; data lines show the inverse afterwards so stale values never match
  task automatic send(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
    @(negedge clk);
    sample_valid = 1'b1;
    left_in = l;
    right_in = r;
    @(negedge clk);
    sample_valid = 1'b0;
    left_in = ~l;
    right_in = ~r;
  endtask : send

endmodule : dvm_audio_source

`default_nettype wire

// *** tb/dvm_volume_mix_tb.sv ***
// self-checking bench for the playback volume and mix block
`default_nettype none

`define DVM_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end

module dvm_volume_mix_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic master_mode = 1'b0;
  logic [2:0] detected_ratio = 3'h3;  // 256 fs while auto
  logic [15:0] reg_rdata;
  logic sample_valid;
  logic [23:0] left_in;
  logic [23:0] right_in;
  logic out_valid;
  logic [23:0] left_out;
  logic [23:0] right_out;
  logic [8:0] left_gain;
  logic [8:0] right_gain;
  logic bclk_out;
  logic filter_narrow;
  logic [7:0] filter_delay_x10;
  int n_fail = 0;
  int tests_run = 0;
  int halves[5] = '{2, 4, 4, 2, 1};  // bit clock half periods at 256 fs

  always #2.5 clk = ~clk;

  dvm_volume_mix u_dvm_volume_mix (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .master_mode(master_mode),
    .detected_ratio(detected_ratio), .sample_valid(sample_valid), .left_in(left_in), .right_in(right_in),
    .out_valid(out_valid), .left_out(left_out), .right_out(right_out), .left_gain(left_gain),
    .right_gain(right_gain), .bclk_out(bclk_out), .filter_narrow(filter_narrow),
    .filter_delay_x10(filter_delay_x10));
  dvm_audio_source u_dvm_audio_source (.clk(clk), .sample_valid(sample_valid), .left_in(left_in),
    .right_in(right_in));

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // read data holds until the next read, so it is checked one cycle late
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    `DVM_CHK(reg_rdata, e)
  endtask : rd

  task automatic frm(input logic [23:0] el, input logic [23:0] er);
    u_dvm_audio_source.send(24'h000010, 24'hFFFFE0);
    `DVM_CHK(out_valid, 1'b1)
    `DVM_CHK(left_out, el)
    `DVM_CHK(right_out, er)
  endtask : frm

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // length of one full bit clock level, bounded on both waits
  task automatic measure(output int n);
    logic b;
    int k;
    b = bclk_out;
    for (k = 0; k < 5000 && bclk_out === b; k++) @(negedge clk);
    b = bclk_out;
    for (n = 0; n < 20 && bclk_out === b; n++) @(negedge clk);
    if (k == 5000 || n == 20) begin
      n_fail++;
      $display("timeout waiting for the bit clock");
      summarize();
    end
  endtask : measure

  initial begin
    int i;
    int n;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    `DVM_CHK(left_gain, 9'h190)
    rd(7'h04, 16'h0000);
    rd(7'h05, 16'h0001);
    rd(7'h06, 16'h0190);
    rd(7'h07, 16'h0190);
    wr(7'h08, 16'hFFFF);
    rd(7'h08, 16'h0000);
    $display("test reset done");
    wr(7'h05, 16'h0000);
    wr(7'h04, 16'h001B);
    frm(24'h000010, 24'hFFFFE0);
    wr(7'h04, 16'h005B);
    frm(24'h000010, 24'h000010);
    wr(7'h04, 16'h009B);
    frm(24'hFFFFE0, 24'hFFFFE0);
    wr(7'h04, 16'h00DB);
    frm(24'hFFFFF8, 24'hFFFFF8);
    wr(7'h05, 16'h0004);
    frm(24'h000000, 24'hFFFFF8);
    wr(7'h05, 16'h0008);
    frm(24'hFFFFF8, 24'h000000);
    rd(7'h04, 16'h00DB);
    $display("test mix done");
    wr(7'h05, 16'h0000);
    wr(7'h04, 16'h001B);
    wr(7'h06, 16'h0100);
    u_dvm_audio_source.send(24'h000100, 24'h000100);
    `DVM_CHK(left_gain, 9'h190)
    rd(7'h06, 16'h0100);
    wr(7'h07, 16'h0320);
    u_dvm_audio_source.send(24'h000100, 24'h000100);
    `DVM_CHK(left_gain, 9'h100)
    `DVM_CHK(right_gain, 9'h120)
    wr(7'h06, 16'h03FF);
    u_dvm_audio_source.send(24'h000100, 24'h000100);
    `DVM_CHK(left_gain, 9'h1BF)
    rd(7'h06, 16'h01FF);
    $display("test apply done");
    wr(7'h05, 16'h0003);
    wr(7'h06, 16'h03BC);
    for (i = 0; i < 4; i++) begin
      u_dvm_audio_source.send(24'h000100, 24'h000100);
      `DVM_CHK(left_gain, i < 3 ? 9'h1BE - 9'(i) : 9'h1BC)
    end
    wr(7'h06, 16'h03BF);
    for (i = 0; i < 3; i++) begin
      u_dvm_audio_source.send(24'h000100, 24'h000100);
      `DVM_CHK(left_gain, 9'h1BD + 9'(i))
    end
    $display("test ramp done");
    wr(7'h05, 16'h0010);
    u_dvm_audio_source.send(24'h000100, 24'h000100);
    wr(7'h06, 16'h0300);
    u_dvm_audio_source.send(24'h000100, 24'h000100);
    `DVM_CHK(left_gain, 9'h1BF)
    u_dvm_audio_source.send(24'hF00000, 24'h000100);
    `DVM_CHK(left_gain, 9'h100)
    wr(7'h05, 16'h0000);
    wr(7'h06, 16'h0350);
    u_dvm_audio_source.send(24'hF00000, 24'h000100);
    `DVM_CHK(left_gain, 9'h150)
    $display("test zero cross done");
    master_mode = 1'b1;
    // reserved divider codes are never written
    for (i = 0; i < 5; i++) begin
      wr(7'h04, 16'h0003 | (16'(i) << 3));
      repeat (12) @(negedge clk);
      measure(n);
      `DVM_CHK(n, halves[i])
    end
    master_mode = 1'b0;
    repeat (3) @(negedge clk);
    `DVM_CHK(bclk_out, 1'b0)
    $display("test bit clock done");
    for (i = 1; i < 8; i++) begin
      wr(7'h04, 16'h0018 | 16'(i));
      repeat (2) @(negedge clk);
      `DVM_CHK(filter_narrow, (i < 3))
      `DVM_CHK(filter_delay_x10, i < 3 ? 8'h41 : 8'h91)
    end
    wr(7'h04, 16'h0018);
    detected_ratio = 3'h1;
    repeat (2) @(negedge clk);
    `DVM_CHK(filter_narrow, 1'b1)
    detected_ratio = 3'h4;
    repeat (2) @(negedge clk);
    `DVM_CHK(filter_narrow, 1'b0)
    $display("test filter done");
    summarize();
  end

endmodule : dvm_volume_mix_tb

`default_nettype wire
